/* design/rso_pkg.sv */
// shared constants and types for the receive-side output logic
package rso_pkg;
  // line modes
  typedef enum logic [1:0] {
    RSO_MODE_T1 = 2'b00,
    RSO_MODE_E1 = 2'b01,
    RSO_MODE_CC = 2'b10,
    RSO_MODE_S6312 = 2'b11
  } rso_mode_t;

  // register byte offsets
  localparam logic [4:0] RSO_OFF_CTRL = 5'h00;
  localparam logic [4:0] RSO_OFF_IO_CONFIG_ONE = 5'h04;
  localparam logic [4:0] RSO_OFF_IO_CONFIG = 5'h08;
  localparam logic [4:0] RSO_OFF_STATE = 5'h0c;
  localparam logic [4:0] RSO_OFF_INT_STATUS = 5'h10;
  localparam logic [4:0] RSO_OFF_INT_CLEAR = 5'h14;
  localparam logic [4:0] RSO_OFF_INT_ENABLE = 5'h18;

  // field positions
  localparam int RSO_CTRL_MODE_LSB = 0;
  localparam int RSO_CTRL_PAYLOAD = 2;
  localparam int RSO_CTRL_SLOW_EN = 3;
  localparam int RSO_IOC1_MFRAME = 5;
  localparam int RSO_IOC1_DOUBLE = 6;
  localparam int RSO_IOC_TXLOSS = 4;
  localparam int RSO_INT_LOS = 0;
  localparam int RSO_INT_FLERR = 1;
  localparam int RSO_INT_TXLOSS = 2;
  localparam int RSO_INT_W = 3;

  // reset values
  localparam logic [3:0] RSO_CTRL_RST = 4'h0;
  localparam logic [7:0] RSO_IOC_RST = 8'h00;

  // frame geometry
  localparam logic [8:0] RSO_T1_FRAME_LAST = 9'h0c0;
  localparam logic [8:0] RSO_E1_FRAME_LAST = 9'h0ff;
  localparam logic [8:0] RSO_E1_TS0_LAST = 9'h007;
  localparam logic [8:0] RSO_E1_TS16_FIRST = 9'h080;
  localparam logic [8:0] RSO_E1_TS16_LAST = 9'h087;
  localparam logic [3:0] RSO_T1_SIG_FRAME_A = 4'h5;
  localparam logic [3:0] RSO_T1_SIG_FRAME_B = 4'hb;

  // detection thresholds and timing
  localparam logic [7:0] RSO_LOS_T1_ZEROS = 8'hc0;
  localparam logic [7:0] RSO_LOS_E1_ZEROS = 8'hff;
  localparam logic [3:0] RSO_TXLOSS_TICKS = 4'hf;
  localparam int RSO_CLK_PERIOD_PS = 4000;
  localparam int RSO_LOS_CC_TIME_US = 120;
  localparam int RSO_LOS_CC_CYCLES =
    (RSO_LOS_CC_TIME_US * 1000000 + RSO_CLK_PERIOD_PS - 1) / RSO_CLK_PERIOD_PS;

  // axi responses
  localparam logic [1:0] RSO_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSO_RESP_SLVERR = 2'h2;
endpackage : rso_pkg

/* design/rso_receive_output.sv */
// receive-side output pin logic with axi4-lite control and interrupt
//
// Operation
// - recovered clock output follows bit rate of the selected line mode
// - t1 payload mode removes the clock pulse at the framing bit
// - e1 payload mode removes the clock during time slots 0 and 16
// - frame sync pulse one clock wide, frame or multiframe by io_config_one bit 5
// - t1 frame pulses double width on signaling frames when io_config_one bit 6 set
// - composite clock mode puts extracted 8khz clock on frame sync output
// - 6312khz mode floats frame sync, slow clock, serial data, frame loss outputs
// - slow clock output floats in t1/e1, carries slow_clock_out in composite mode if enabled
// - serial data output carries nrz data updated on recovered clock rising edge
// - serial data output floats in composite clock mode
// - io_config bit 4 picks frame search or tx clock loss report in t1/e1
// - frame search report high while synchronizer hunts for alignment
// - tx clock loss report after 15 scaled master ticks without transition
// - composite mode frame loss output high on 8khz or slow_clock_out component errors
// - t1 loss of signal after 192 consecutive zeros
// - e1 loss of signal after 255 consecutive zeros
// - composite mode loss of signal after zeros for 120 microseconds
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module rso_receive_output
  import rso_pkg::*;
#(
  parameter int LOS_CC_CYCLES = RSO_LOS_CC_CYCLES
) (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic [4:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [4:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_BIT_STROBE,
  input wire logic I_RX_DATA,
  input wire logic I_RX_PULSE,
  input wire logic I_FRAME_START,
  input wire logic I_MFRAME_START,
  input wire logic I_FRAME_SEARCH,
  input wire logic I_TX_CLOCK_IN,
  input wire logic I_MCLK_TICK,
  input wire logic I_CC_8K,
  input wire logic I_CC_400,
  input wire logic I_CC_ERROR,
  output logic O_RX_CLOCK,
  output logic O_FRAME_SYNC_OUT,
  output logic O_FRAME_SYNC_OUT_OE,
  output logic O_SLOW_CLOCK_OUT,
  output logic O_SLOW_CLOCK_OUT_OE,
  output logic O_RECEIVED_SERIAL_OUT,
  output logic O_RECEIVED_SERIAL_OUT_OE,
  output logic O_FRAME_LOSS_ERROR_OUT,
  output logic O_FRAME_LOSS_ERROR_OUT_OE,
  output logic O_LOS,
  output logic O_IRQ
);

  // true where the recovered clock is removed in payload mode
  function automatic logic gap_bit(input rso_mode_t m, input logic [8:0] b);
    logic r;
    r = 1'b0;
    if (m == RSO_MODE_T1) begin
      r = (b == 9'h000);
    end else if (m == RSO_MODE_E1) begin
      r = (b <= RSO_E1_TS0_LAST) || (b >= RSO_E1_TS16_FIRST && b <= RSO_E1_TS16_LAST);
    end
    return r;
  endfunction : gap_bit

  // true for framed line modes
  function automatic logic framed(input rso_mode_t m);
    return (m == RSO_MODE_T1) || (m == RSO_MODE_E1);
  endfunction : framed

  logic [3:0] ctrl_q;
  logic [7:0] ioc1_q, ioc_q;
  logic [RSO_INT_W-1:0] int_stat_q, int_en_q;
  rso_mode_t mode;
  logic payload;
  logic aw_held_q, w_held_q;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic [RSO_INT_W-1:0] clr_bits;
  logic [8:0] bit_idx_q;
  logic [3:0] frame_idx_q;
  logic [8:0] cur_bit;
  logic [3:0] cur_frame;
  logic rclk_q, fs_q, fs_left_q, boundary, dbl;
  logic cc8k_q, cc400_q, received_serial_out_q, flerr_q, tx_prev_q;
  logic [3:0] tx_clock_loss_report_cnt_q;
  logic tx_clock_loss_report_q;
  logic [7:0] zero_cnt_q;
  logic [15:0] cc_cnt_q;
  logic los_q;
  logic [RSO_INT_W-1:0] ev_prev_q, ev_now;

  assign mode = rso_mode_t'(ctrl_q[RSO_CTRL_MODE_LSB +: 2]);
  assign payload = ctrl_q[RSO_CTRL_PAYLOAD];

  // axi write: address and data taken in either order, response after both
  assign O_AWREADY = !aw_held_q && !bvalid_q;
  assign O_WREADY = !w_held_q && !bvalid_q;
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RSO_RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_held_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q == RSO_OFF_STATE || awaddr_q == RSO_OFF_INT_STATUS ||
                    awaddr_q > RSO_OFF_INT_ENABLE) ? RSO_RESP_SLVERR : RSO_RESP_OKAY;
      end else if (bvalid_q && I_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;

  // writable registers; only byte lane 0 carries bits
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl_q <= RSO_CTRL_RST;
      ioc1_q <= RSO_IOC_RST;
      ioc_q <= RSO_IOC_RST;
      int_en_q <= '0;
    end else if (wr_go && wstrb_q[0]) begin
      unique case (awaddr_q)
        RSO_OFF_CTRL: ctrl_q <= wdata_q[3:0];
        RSO_OFF_IO_CONFIG_ONE: ioc1_q <= wdata_q[7:0];
        RSO_OFF_IO_CONFIG: ioc_q <= wdata_q[7:0];
        RSO_OFF_INT_ENABLE: int_en_q <= wdata_q[RSO_INT_W-1:0];
        default: ;
      endcase
    end
  end
  assign clr_bits = (wr_go && wstrb_q[0] && awaddr_q == RSO_OFF_INT_CLEAR) ?
                    wdata_q[RSO_INT_W-1:0] : '0;

  // axi read, one cycle after the address is taken
  assign O_ARREADY = !rvalid_q;
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RSO_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q <= RSO_RESP_OKAY;
      unique case (I_ARADDR)
        RSO_OFF_CTRL: rdata_q <= {28'h0, ctrl_q};
        RSO_OFF_IO_CONFIG_ONE: rdata_q <= {24'h0, ioc1_q};
        RSO_OFF_IO_CONFIG: rdata_q <= {24'h0, ioc_q};
        RSO_OFF_STATE: rdata_q <= {27'h0, I_FRAME_SEARCH, fs_q, tx_clock_loss_report_q, flerr_q, los_q};
        RSO_OFF_INT_STATUS: rdata_q <= {29'h0, int_stat_q};
        RSO_OFF_INT_ENABLE: rdata_q <= {29'h0, int_en_q};
        RSO_OFF_INT_CLEAR: rdata_q <= 32'h0000_0000;
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RSO_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && I_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;

  // bit and frame position of the bit now being strobed
  assign cur_bit = I_FRAME_START ? 9'h000 : bit_idx_q + 9'h001;
  assign cur_frame = I_MFRAME_START ? 4'h0 : frame_idx_q + 4'h1;
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      bit_idx_q <= 9'h000;
      frame_idx_q <= 4'h0;
    end else if (I_BIT_STROBE) begin
      bit_idx_q <= cur_bit;
      if (I_FRAME_START) begin
        frame_idx_q <= cur_frame;
      end
    end
  end

  // recovered clock: one high cycle per bit, gapped in payload mode
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rclk_q <= 1'b0;
    end else begin
      rclk_q <= I_BIT_STROBE && !(payload && gap_bit(mode, cur_bit));
    end
  end
  assign O_RX_CLOCK = rclk_q;

  // frame sync pulse spans one or two bit periods
  assign boundary = I_BIT_STROBE && I_FRAME_START &&
                    (!ioc1_q[RSO_IOC1_MFRAME] || I_MFRAME_START);
  assign dbl = (mode == RSO_MODE_T1) && !ioc1_q[RSO_IOC1_MFRAME] && ioc1_q[RSO_IOC1_DOUBLE] &&
               (cur_frame == RSO_T1_SIG_FRAME_A || cur_frame == RSO_T1_SIG_FRAME_B);
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      fs_q <= 1'b0;
      fs_left_q <= 1'b0;
    end else if (boundary) begin
      fs_q <= 1'b1;
      fs_left_q <= dbl;
    end else if (I_BIT_STROBE && fs_q) begin
      if (fs_left_q) begin
        fs_left_q <= 1'b0;
      end else begin
        fs_q <= 1'b0;
      end
    end
  end

  // data outputs registered; serial data moves with the clock rising edge
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      cc8k_q <= 1'b0;
      cc400_q <= 1'b0;
      received_serial_out_q <= 1'b0;
    end else begin
      cc8k_q <= I_CC_8K;
      cc400_q <= I_CC_400;
      if (I_BIT_STROBE) begin
        received_serial_out_q <= I_RX_DATA;
      end
    end
  end

  // tx clock loss: count scaled master ticks since the last tx clock edge
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tx_prev_q <= 1'b0;
      tx_clock_loss_report_cnt_q <= 4'h0;
      tx_clock_loss_report_q <= 1'b0;
    end else begin
      tx_prev_q <= I_TX_CLOCK_IN;
      if (I_TX_CLOCK_IN != tx_prev_q) begin
        tx_clock_loss_report_cnt_q <= 4'h0;
      end else if (I_MCLK_TICK && tx_clock_loss_report_cnt_q != RSO_TXLOSS_TICKS) begin
        tx_clock_loss_report_cnt_q <= tx_clock_loss_report_cnt_q + 4'h1;
      end
      tx_clock_loss_report_q <= (tx_clock_loss_report_cnt_q == RSO_TXLOSS_TICKS);
    end
  end

  // frame loss / error source depends on mode and io_config bit 4
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      flerr_q <= 1'b0;
    end else if (mode == RSO_MODE_CC) begin
      flerr_q <= I_CC_ERROR;
    end else if (ioc_q[RSO_IOC_TXLOSS]) begin
      flerr_q <= tx_clock_loss_report_q;
    end else begin
      flerr_q <= I_FRAME_SEARCH;
    end
  end

  // loss of signal: counters clear on a line pulse, the zero counter only on one that comes with a bit strobe
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      zero_cnt_q <= 8'h00;
      cc_cnt_q <= 16'h0000;
    end else begin
      if (I_BIT_STROBE) begin
        if (I_RX_PULSE) begin
          zero_cnt_q <= 8'h00;
        end else if (zero_cnt_q != RSO_LOS_E1_ZEROS) begin
          zero_cnt_q <= zero_cnt_q + 8'h01;
        end
      end
      if (I_RX_PULSE) begin
        cc_cnt_q <= 16'h0000;
      end else if (cc_cnt_q != 16'(LOS_CC_CYCLES)) begin
        cc_cnt_q <= cc_cnt_q + 16'h0001;
      end
    end
  end
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      los_q <= 1'b0;
    end else begin
      unique case (mode)
        RSO_MODE_T1: los_q <= (zero_cnt_q >= RSO_LOS_T1_ZEROS);
        RSO_MODE_E1: los_q <= (zero_cnt_q == RSO_LOS_E1_ZEROS);
        RSO_MODE_CC: los_q <= (cc_cnt_q == 16'(LOS_CC_CYCLES));
        RSO_MODE_S6312: los_q <= 1'b0;
      endcase
    end
  end

  // pin drivers; enables float pins a mode does not use
  assign O_FRAME_SYNC_OUT = (mode == RSO_MODE_CC) ? cc8k_q : fs_q;
  assign O_FRAME_SYNC_OUT_OE = (mode != RSO_MODE_S6312);
  assign O_SLOW_CLOCK_OUT = cc400_q;
  assign O_SLOW_CLOCK_OUT_OE = (mode == RSO_MODE_CC) && ctrl_q[RSO_CTRL_SLOW_EN];
  assign O_RECEIVED_SERIAL_OUT = received_serial_out_q;
  assign O_RECEIVED_SERIAL_OUT_OE = framed(mode);
  assign O_FRAME_LOSS_ERROR_OUT = flerr_q;
  assign O_FRAME_LOSS_ERROR_OUT_OE = (mode != RSO_MODE_S6312);
  assign O_LOS = los_q;

  // sticky interrupt status on rising alarms; a new event beats a clear
  assign ev_now = {tx_clock_loss_report_q, flerr_q, los_q};
  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ev_prev_q <= '0;
      int_stat_q <= '0;
    end else begin
      ev_prev_q <= ev_now;
      int_stat_q <= (int_stat_q & ~clr_bits) | (ev_now & ~ev_prev_q);
    end
  end
  assign O_IRQ = |(int_stat_q & int_en_q);

  // checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  sequence payload_gap_s;
    I_BIT_STROBE && payload && gap_bit(mode, cur_bit);
  endsequence
  // strobe that ends a single pulse, and strobe that stretches a double one
  sequence fs_end_s;
    I_BIT_STROBE && !boundary && fs_q && !fs_left_q;
  endsequence
  sequence fs_extend_s;
    I_BIT_STROBE && !boundary && fs_q && fs_left_q;
  endsequence

  t1_fbit_gap_a: assert property (payload_gap_s and (mode == RSO_MODE_T1) |=> !O_RX_CLOCK)
    else $error("t1 framing bit clock not gapped");
  e1_slot_gap_a: assert property (payload_gap_s and (mode == RSO_MODE_E1) |=> !O_RX_CLOCK)
    else $error("e1 slot clock not gapped");
  rclk_pass_a: assert property (I_BIT_STROBE && !payload |=>
    O_RX_CLOCK ##1 (!O_RX_CLOCK || $past(I_BIT_STROBE))) else $error("recovered clock missing");
  fsync_width_a: assert property (fs_end_s |=> !fs_q)
    else $error("frame sync wider than one bit");
  fsync_double_a: assert property (fs_extend_s |=> fs_q && !fs_left_q)
    else $error("double frame sync too short");
  cc_8k_out_a: assert property (mode == RSO_MODE_CC && $stable(mode) |->
    O_FRAME_SYNC_OUT == $past(I_CC_8K)) else $error("8khz not on frame sync");
  s6312_float_a: assert property (mode == RSO_MODE_S6312 |-> !O_FRAME_SYNC_OUT_OE &&
    !O_SLOW_CLOCK_OUT_OE && !O_RECEIVED_SERIAL_OUT_OE && !O_FRAME_LOSS_ERROR_OUT_OE)
    else $error("pin driven in 6312 mode");
  received_serial_out_follow_a: assert property (I_BIT_STROBE |=>
    O_RECEIVED_SERIAL_OUT == $past(I_RX_DATA)) else $error("serial data not updated");
  // a settled report source is needed, hence both config registers stable
  search_report_a: assert property (framed(mode) && !ioc_q[RSO_IOC_TXLOSS] &&
    $stable(ctrl_q) && $stable(ioc_q) |-> O_FRAME_LOSS_ERROR_OUT == $past(I_FRAME_SEARCH))
    else $error("frame search not reported");
  txloss_count_a: assert property (tx_clock_loss_report_cnt_q == RSO_TXLOSS_TICKS &&
    I_TX_CLOCK_IN == tx_prev_q |=> tx_clock_loss_report_q) else $error("tx clock loss missed");
  t1_los_a: assert property (mode == RSO_MODE_T1 && $stable(mode) &&
    zero_cnt_q == RSO_LOS_T1_ZEROS |=> O_LOS) else $error("t1 loss of signal missed");
  los_clear_a: assert property (framed(mode) && I_BIT_STROBE && I_RX_PULSE &&
    $stable(mode) |=> ##1 !O_LOS) else $error("loss of signal did not clear");

endmodule : rso_receive_output

/* bench/rso_sink.sv */
// downstream consumer that clocks in serial data on the recovered clock
`timescale 1ns/10ps
module rso_sink (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic i_rclk,
  input wire logic i_ser,
  output logic [15:0] o_count,
  output logic [7:0] o_bits
);
  // count clock pulses and keep the last eight bits, newest in bit 0
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      o_count <= 16'h0000;
      o_bits <= 8'h00;
    end else if (i_rclk) begin
      o_count <= o_count + 16'h0001;
      o_bits <= {o_bits[6:0], i_ser};
    end
  end
endmodule : rso_sink

/* bench/tb_receive_side_output_logic.sv */
// self-checking bench for the receive-side output logic
`timescale 1ns/10ps
module tb_receive_side_output_logic;
  import rso_pkg::*;
  // stimulus, all driven right after the rising edge
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, clr = 1'b0;
  logic stb = 1'b0, rxd = 1'b0, rxp = 1'b0, fst = 1'b0, srch = 1'b0, txc = 1'b0;
  logic mtick = 1'b0, c8k = 1'b0, c400 = 1'b0, cerr = 1'b0, mfst = 1'b0;
  logic awr, wrdy, bv, arr, rv, rclk, fs, fs_oe, slw, slw_oe, ser, ser_oe;
  logic fle, fle_oe, los, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] cnt;
  logic [7:0] bits;
  int miscompares = 0;
  int tests_run = 0;

  // 250 mhz
  always #2 clk = ~clk;

  // short composite-clock silence window keeps the run brief
  rso_receive_output #(.LOS_CC_CYCLES(50)) u_dut (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bresp),
    .O_BVALID(bv), .I_BREADY(brdy), .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rrdy), .I_BIT_STROBE(stb),
    .I_RX_DATA(rxd), .I_RX_PULSE(rxp), .I_FRAME_START(fst), .I_MFRAME_START(mfst),
    .I_FRAME_SEARCH(srch), .I_TX_CLOCK_IN(txc), .I_MCLK_TICK(mtick), .I_CC_8K(c8k),
    .I_CC_400(c400), .I_CC_ERROR(cerr), .O_RX_CLOCK(rclk), .O_FRAME_SYNC_OUT(fs),
    .O_FRAME_SYNC_OUT_OE(fs_oe), .O_SLOW_CLOCK_OUT(slw), .O_SLOW_CLOCK_OUT_OE(slw_oe),
    .O_RECEIVED_SERIAL_OUT(ser), .O_RECEIVED_SERIAL_OUT_OE(ser_oe),
    .O_FRAME_LOSS_ERROR_OUT(fle), .O_FRAME_LOSS_ERROR_OUT_OE(fle_oe), .O_LOS(los),
    .O_IRQ(irq));

  rso_sink u_sink (.i_clk(clk), .i_clr(clr), .i_rclk(rclk), .i_ser(ser), .o_count(cnt),
    .o_bits(bits));

  // verdict, the only exit of the run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // case-equality compare, counted
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // axi write; address and data offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'bxx;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    // no cycle count assumed; only the watchdog ends a lost answer
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) begin
        r = bresp;
        brdy <= 1'b0;
        break;
      end
    end
    chk({30'h0, r}, {30'h0, er});
  endtask : wr

  // axi read with data and response check
  task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'hx;
    r = 2'bxx;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        d = rdata;
        r = rresp;
        rrdy <= 1'b0;
        break;
      end
    end
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd

  // one line bit; strobes kept four cycles apart, above the two-cycle minimum
  task automatic sb(input logic d, input logic f);
    @(posedge clk);
    stb <= 1'b1;
    rxd <= d;
    rxp <= d;
    fst <= f;
    @(posedge clk);
    stb <= 1'b0;
    rxp <= 1'b0;
    fst <= 1'b0;
    wt(2);
  endtask : sb

  // reset values, unmapped and read-only places
  task automatic t_regs;
    chk({fs_oe, slw_oe, ser_oe, fle_oe}, 32'hb);
    rd(RSO_OFF_CTRL, 32'h0, RSO_RESP_OKAY);
    rd(5'h1c, 32'h0, RSO_RESP_SLVERR);
    wr(RSO_OFF_STATE, 32'h1, RSO_RESP_SLVERR);
    rd(RSO_OFF_INT_CLEAR, 32'h0, RSO_RESP_OKAY);
  endtask : t_regs

  // one frame of alternating data; clock pulses and last bits seen downstream
  task automatic t_frame(input logic [31:0] ctl, input logic [31:0] io1, input int n,
                         input logic [15:0] ec, input logic [7:0] eb, input logic efs);
    wr(RSO_OFF_CTRL, ctl, RSO_RESP_OKAY);
    wr(RSO_OFF_IO_CONFIG_ONE, io1, RSO_RESP_OKAY);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    sb(1'b0, 1'b1);
    chk({31'h0, fs}, {31'h0, efs});
    sb(1'b1, 1'b0);
    chk({31'h0, fs}, 32'h0);
    for (int i = 2; i < n; i++) sb(i[0], 1'b0);
    chk({16'h0, cnt}, {16'h0, ec});
    chk({24'h0, bits}, {24'h0, eb});
  endtask : t_frame

  // t1 double pulse on the sixth frame, then pulses on multiframe starts only
  task automatic t_sig;
    wr(RSO_OFF_CTRL, 32'h0, RSO_RESP_OKAY);
    wr(RSO_OFF_IO_CONFIG_ONE, 32'h40, RSO_RESP_OKAY);
    for (int f = 0; f < 6; f++) begin
      mfst <= (f == 0);
      sb(1'b1, 1'b1);
      sb(1'b1, 1'b0);
      chk({31'h0, fs}, {31'h0, (f == 5)});
      sb(1'b1, 1'b0);
      chk({31'h0, fs}, 32'h0);
    end
    wr(RSO_OFF_IO_CONFIG_ONE, 32'h20, RSO_RESP_OKAY);
    mfst <= 1'b1;
    sb(1'b1, 1'b1);
    chk({31'h0, fs}, 32'h1);
    mfst <= 1'b0;
    sb(1'b1, 1'b0);
    sb(1'b1, 1'b1);
    chk({31'h0, fs}, 32'h0);
  endtask : t_sig

  // zero run one short of the threshold, then the last zero, then a pulse
  task automatic t_los(input logic [31:0] ctl, input int n);
    wr(RSO_OFF_CTRL, ctl, RSO_RESP_OKAY);
    sb(1'b1, 1'b0);
    for (int i = 1; i < n; i++) sb(1'b0, 1'b0);
    chk({31'h0, los}, 32'h0);
    sb(1'b0, 1'b0);
    wt(2);
    chk({31'h0, los}, 32'h1);
    sb(1'b1, 1'b0);
    wt(3);
    chk({31'h0, los}, 32'h0);
  endtask : t_los

  // sticky status, mask and clear of the loss-of-signal event
  task automatic t_irq;
    rd(RSO_OFF_INT_STATUS, 32'h1, RSO_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(RSO_OFF_INT_ENABLE, 32'h1, RSO_RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wr(RSO_OFF_INT_CLEAR, 32'h1, RSO_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    rd(RSO_OFF_INT_STATUS, 32'h0, RSO_RESP_OKAY);
    wr(RSO_OFF_INT_ENABLE, 32'h0, RSO_RESP_OKAY);
  endtask : t_irq

  // frame search report versus tx clock loss report
  task automatic t_fl;
    wr(RSO_OFF_IO_CONFIG, 32'h0, RSO_RESP_OKAY);
    @(posedge clk);
    srch <= 1'b1;
    wt(3);
    chk({31'h0, fle}, 32'h1);
    wr(RSO_OFF_IO_CONFIG, 32'h10, RSO_RESP_OKAY);
    wt(2);
    chk({31'h0, fle}, 32'h0);
    for (int i = 0; i < 15; i++) begin
      if (i == 14) chk({31'h0, fle}, 32'h0);
      @(posedge clk);
      mtick <= 1'b1;
      @(posedge clk);
      mtick <= 1'b0;
    end
    wt(3);
    chk({31'h0, fle}, 32'h1);
    srch <= 1'b0;
    txc <= 1'b1;
    wr(RSO_OFF_IO_CONFIG, 32'h0, RSO_RESP_OKAY);
  endtask : t_fl

  // pin ownership and sources in the 6312 khz and composite modes
  task automatic t_modes;
    wr(RSO_OFF_CTRL, 32'h3, RSO_RESP_OKAY);
    chk({fs_oe, slw_oe, ser_oe, fle_oe}, 32'h0);
    wr(RSO_OFF_CTRL, 32'ha, RSO_RESP_OKAY);
    chk({ser_oe, slw_oe, fs_oe}, 32'h3);
    c8k <= 1'b1;
    c400 <= 1'b1;
    cerr <= 1'b1;
    wt(3);
    chk({fs, slw, fle}, 32'h7);
    c8k <= 1'b0;
    c400 <= 1'b0;
    cerr <= 1'b0;
    wt(3);
    chk({fs, slw, fle}, 32'h0);
    wr(RSO_OFF_CTRL, 32'h2, RSO_RESP_OKAY);
    chk({31'h0, slw_oe}, 32'h0);
    // composite silence measured in system clocks since the last pulse
    rxp <= 1'b1;
    @(posedge clk);
    rxp <= 1'b0;
    wt(40);
    chk({31'h0, los}, 32'h0);
    wt(20);
    chk({31'h0, los}, 32'h1);
    rxp <= 1'b1;
    @(posedge clk);
    rxp <= 1'b0;
    wt(4);
    chk({31'h0, los}, 32'h0);
  endtask : t_modes

  // main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_frame(32'h4, 32'h0, 193, 16'd192, 8'haa, 1'b1);
    t_frame(32'h0, 32'h20, 193, 16'd193, 8'haa, 1'b0);
    t_frame(32'h5, 32'h0, 256, 16'd240, 8'h55, 1'b1);
    t_sig();
    t_los(32'h0, 192);
    t_irq();
    t_los(32'h1, 255);
    t_fl();
    t_modes();
    report_and_stop();
  end

  // watchdog, well above the roughly five thousand cycles the tests need
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_receive_side_output_logic
